// ==== shared/supervisor_regs.vh ====
/*
 * Constants of the triple supply reset supervisor: delay and watchdog selections
 * and their cycle counts at a 100 MHz system clock.
 * Assumes the includer works on clk_sys at 100 MHz.
 */
// How it works
// - Start, clock low, stop restarts the watchdog
// - Watchdog expiry without restart drives timeout active
// - Timeout output active low, open drain, while expired
// - Write protect high refuses every setting write
// - Reset held until main supply good for delay
// - Manual reset holds reset, plus delay after release
// - Main supply low asserts reset at once
// - Second fail output follows comparator, no delay
// - Third fail output open drain, low while below
// - Third fail output ignores the power-up delay
// - Early low output follows main comparator directly
// - Two stored bits select the watchdog period
`ifndef SUPERVISOR_REGS_VH
`define SUPERVISOR_REGS_VH

// ----------------------------------------------------------------------------
// Selection codes
// ----------------------------------------------------------------------------
`define WD_SEL_SHORT 2'h0
`define WD_SEL_MID 2'h1
`define WD_SEL_LONG 2'h2
`define WD_SEL_OFF 2'h3
`define WD_SEL_RESET 2'h0
`define RST_SEL_RESET 2'h0

// ----------------------------------------------------------------------------
// Times in microseconds and cycle counts at 100 cycles per microsecond
// ----------------------------------------------------------------------------
`define CYC_PER_US 100
`define RST_T0_US 50000
`define RST_T1_US 200000
`define RST_T2_US 400000
`define RST_T3_US 800000
`define WD_T0_US 25000
`define WD_T1_US 200000
`define WD_T2_US 1400000
`define CNT_W 28
`define MR_DEBOUNCE_CYC 16'h0010
`define DB_W 16
`define CNT_ZERO 28'h0000000
`define CNT_ONE 28'h0000001

`endif

// ==== verilog/level_debounce.v ====
/*
 * Debouncer for one level input: the output takes a new level only after the
 * input has held it for a set number of cycles.
 * Assumes the input is already synchronous to clk_sys.
 */
`include "supervisor_regs.vh"

module level_debounce #(
   parameter [`DB_W-1:0] HOLD_CYC = `MR_DEBOUNCE_CYC
) (
   clk_sys,
   nrst,
   level_in,
   level_out
);
   input wire clk_sys;
   input wire nrst;
   input wire level_in;
   output reg level_out;

   reg [`DB_W-1:0] cnt_q;

   // Starts high so a released button does not fake a reset press.
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= {`DB_W{1'b0}};
         level_out <= 1'b1;
      end else if (level_in == level_out) begin
         cnt_q <= {`DB_W{1'b0}};
      end else if (cnt_q == HOLD_CYC - 1'b1) begin
         cnt_q <= {`DB_W{1'b0}};
         level_out <= level_in;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
endmodule

// ==== verilog/triple_supply_reset_supervisor.v ====
/*
 * Reset and supply-fail logic of a triple supply supervisor with a bus-activity
 * watchdog. Comparator results arrive as digital levels, high meaning the
 * supply is above its threshold.
 * Assumes every input is synchronous to clk_sys; the bus lines are sampled.
 */
`include "supervisor_regs.vh"

module triple_supply_reset_supervisor #(
   parameter [`CNT_W-1:0] RST_CYC_0 = `RST_T0_US * `CYC_PER_US,
   parameter [`CNT_W-1:0] RST_CYC_1 = `RST_T1_US * `CYC_PER_US,
   parameter [`CNT_W-1:0] RST_CYC_2 = `RST_T2_US * `CYC_PER_US,
   parameter [`CNT_W-1:0] RST_CYC_3 = `RST_T3_US * `CYC_PER_US,
   parameter [`CNT_W-1:0] WD_CYC_0 = `WD_T0_US * `CYC_PER_US,
   parameter [`CNT_W-1:0] WD_CYC_1 = `WD_T1_US * `CYC_PER_US,
   parameter [`CNT_W-1:0] WD_CYC_2 = `WD_T2_US * `CYC_PER_US
) (
   clk_sys,
   nrst,
   main_above_trip,
   second_supply_sense,
   third_supply_sense,
   manual_reset_n,
   scl_in,
   sda_in,
   write_protect,
   set_write,
   set_wd_sel,
   set_rst_sel,
   wd_sel,
   rst_sel,
   system_reset,
   early_low_supply_n,
   second_supply_fail_n,
   third_supply_fail_out,
   third_supply_fail_oe_n,
   watchdog_timeout_out,
   watchdog_timeout_oe_n
);
   input wire clk_sys;
   input wire nrst;
   input wire main_above_trip;
   input wire second_supply_sense;
   input wire third_supply_sense;
   input wire manual_reset_n;
   input wire scl_in;
   input wire sda_in;
   input wire write_protect;
   input wire set_write;
   input wire [1:0] set_wd_sel;
   input wire [1:0] set_rst_sel;
   output reg [1:0] wd_sel;
   output reg [1:0] rst_sel;
   output reg system_reset;
   output reg early_low_supply_n;
   output reg second_supply_fail_n;
   output reg third_supply_fail_out;
   output reg third_supply_fail_oe_n;
   output reg watchdog_timeout_out;
   output reg watchdog_timeout_oe_n;

   // ---------------------------------------------------------------------------
   // Bus line sampling and watchdog restart sequence
   // ---------------------------------------------------------------------------
   localparam SQ_IDLE = 2'h0;
   localparam SQ_START = 2'h1;
   localparam SQ_CLOCKED = 2'h2;

   reg scl_q;
   reg sda_q;
   reg [1:0] seq_q;
   reg [1:0] seq_d;
   reg restart_q;
   wire start_cond;
   wire stop_cond;
   wire scl_fall;
   reg restart_q_d;

   assign start_cond = scl_q & scl_in & sda_q & ~sda_in;
   assign stop_cond = scl_q & scl_in & ~sda_q & sda_in;
   assign scl_fall = scl_q & ~scl_in;

   // Start, then a low clock, then stop; a fresh start restarts the match.
   always @* begin
      seq_d = seq_q;
      restart_q_d = 1'b0;
      case (seq_q)
         SQ_IDLE: begin
            if (start_cond) begin
               seq_d = SQ_START;
            end
         end
         SQ_START: begin
            if (scl_fall) begin
               seq_d = SQ_CLOCKED;
            end else if (stop_cond) begin
               seq_d = SQ_IDLE;
            end
         end
         SQ_CLOCKED: begin
            if (stop_cond) begin
               seq_d = SQ_IDLE;
               restart_q_d = 1'b1;
            end else if (start_cond) begin
               seq_d = SQ_START;
            end
         end
         default: begin
            seq_d = SQ_IDLE;
         end
      endcase
   end

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         seq_q <= SQ_IDLE;
         restart_q <= 1'b0;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         seq_q <= seq_d;
         restart_q <= restart_q_d;
      end
   end

   // ---------------------------------------------------------------------------
   // Stored selections, guarded by write protect
   // ---------------------------------------------------------------------------
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wd_sel <= `WD_SEL_RESET;
         rst_sel <= `RST_SEL_RESET;
      end else if (set_write && !write_protect) begin
         wd_sel <= set_wd_sel;
         rst_sel <= set_rst_sel;
      end
   end

   // ---------------------------------------------------------------------------
   // Watchdog timer
   // ---------------------------------------------------------------------------
   reg [`CNT_W-1:0] wd_limit;
   reg [`CNT_W-1:0] wd_cnt_q;
   reg wd_expired_q;
   wire wd_next_expired;

   assign wd_next_expired = wd_expired_q;

   always @* begin
      case (wd_sel)
         `WD_SEL_SHORT: wd_limit = WD_CYC_0;
         `WD_SEL_MID: wd_limit = WD_CYC_1;
         `WD_SEL_LONG: wd_limit = WD_CYC_2;
         default: wd_limit = `CNT_ZERO;
      endcase
   end

   // Held off while reset is out, so the host is not blamed for its own boot.
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wd_cnt_q <= `CNT_ZERO;
         wd_expired_q <= 1'b0;
      end else if (wd_sel == `WD_SEL_OFF || system_reset || restart_q) begin
         wd_cnt_q <= `CNT_ZERO;
         wd_expired_q <= 1'b0;
      end else if (wd_cnt_q >= wd_limit - `CNT_ONE) begin
         wd_expired_q <= 1'b1;
      end else begin
         wd_cnt_q <= wd_cnt_q + `CNT_ONE;
      end
   end

   // ---------------------------------------------------------------------------
   // System reset with selectable release delay
   // ---------------------------------------------------------------------------
   wire mr_clean_n;
   reg [`CNT_W-1:0] rst_limit;
   reg [`CNT_W-1:0] rst_cnt_q;
   wire hold_cause;

   level_debounce #(
      .HOLD_CYC(`MR_DEBOUNCE_CYC)
   ) u_mr_debounce (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .level_in(manual_reset_n),
      .level_out(mr_clean_n)
   );

   always @* begin
      case (rst_sel)
         2'h0: rst_limit = RST_CYC_0;
         2'h1: rst_limit = RST_CYC_1;
         2'h2: rst_limit = RST_CYC_2;
         default: rst_limit = RST_CYC_3;
      endcase
   end

   assign hold_cause = ~main_above_trip | ~mr_clean_n;

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rst_cnt_q <= `CNT_ZERO;
         system_reset <= 1'b1;
      end else if (hold_cause) begin
         rst_cnt_q <= `CNT_ZERO;
         system_reset <= 1'b1;
      end else if (rst_cnt_q >= rst_limit - `CNT_ONE) begin
         system_reset <= 1'b0;
      end else begin
         rst_cnt_q <= rst_cnt_q + `CNT_ONE;
      end
   end

   // ---------------------------------------------------------------------------
   // Undelayed supply and watchdog outputs
   // ---------------------------------------------------------------------------
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         early_low_supply_n <= 1'b0;
         second_supply_fail_n <= 1'b0;
         third_supply_fail_out <= 1'b0;
         third_supply_fail_oe_n <= 1'b0;
         watchdog_timeout_out <= 1'b0;
         watchdog_timeout_oe_n <= 1'b1;
      end else begin
         early_low_supply_n <= main_above_trip;
         second_supply_fail_n <= second_supply_sense;
         third_supply_fail_out <= 1'b0;
         third_supply_fail_oe_n <= third_supply_sense;
         watchdog_timeout_out <= 1'b0;
         watchdog_timeout_oe_n <= ~wd_next_expired;
      end
   end
endmodule

// ==== sim/host_bus_model.sv ====
/* Host on the two-wire bus: each kick sends start, clock low, clock high, stop.
   Assumes a pulled-up bus that idles high. */
module host_bus_model (
   input wire logic clk_sys,
   input wire logic kick,
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   always @(posedge clk_sys) begin
      if (kick) begin
         @(posedge clk_sys) sda <= 1'b0;
         @(posedge clk_sys) scl <= 1'b0;
         @(posedge clk_sys) scl <= 1'b1;
         @(posedge clk_sys) sda <= 1'b1;
      end
   end
endmodule

// ==== sim/supervisor_assertions.sv ====
/* Port checker of the supervisor, bound to its top module.
   Assumes one clk_sys domain and nrst active low. */
module supervisor_assertions (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic main_above_trip,
   input wire logic second_supply_sense,
   input wire logic third_supply_sense,
   input wire logic write_protect,
   input wire logic set_write,
   input wire logic [1:0] set_wd_sel,
   input wire logic [1:0] set_rst_sel,
   input wire logic [1:0] wd_sel,
   input wire logic [1:0] rst_sel,
   input wire logic system_reset,
   input wire logic early_low_supply_n,
   input wire logic second_supply_fail_n,
   input wire logic third_supply_fail_oe_n,
   input wire logic watchdog_timeout_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence main_back_s;
      !main_above_trip ##1 main_above_trip;
   endsequence
   early_follow_a: assert property (
      1'b1 |=> early_low_supply_n == $past(main_above_trip))
      else $error("early low output lags");
   second_follow_a: assert property (
      1'b1 |=> second_supply_fail_n == $past(second_supply_sense))
      else $error("second fail output lags");
   third_follow_a: assert property (
      1'b1 |=> third_supply_fail_oe_n == $past(third_supply_sense))
      else $error("third fail output lags");
   brownout_a: assert property (!main_above_trip |=> system_reset)
      else $error("reset missing on low supply");
   recover_hold_a: assert property (main_back_s |=> system_reset [*8])
      else $error("reset released too early");
   wp_block_a: assert property (
      write_protect && set_write |=> $stable(wd_sel) && $stable(rst_sel))
      else $error("write taken while protected");
   sel_load_a: assert property (
      set_write && !write_protect |=>
      wd_sel == $past(set_wd_sel) && rst_sel == $past(set_rst_sel))
      else $error("selection not loaded");
   wd_off_a: assert property (
      $fell(watchdog_timeout_oe_n) |-> $past(wd_sel) != 2'h3)
      else $error("watchdog fired while off");
endmodule

bind triple_supply_reset_supervisor supervisor_assertions chk_u (
   .clk_sys(clk_sys), .nrst(nrst), .main_above_trip(main_above_trip),
   .second_supply_sense(second_supply_sense), .third_supply_sense(third_supply_sense),
   .write_protect(write_protect), .set_write(set_write), .set_wd_sel(set_wd_sel),
   .set_rst_sel(set_rst_sel), .wd_sel(wd_sel), .rst_sel(rst_sel),
   .system_reset(system_reset), .early_low_supply_n(early_low_supply_n),
   .second_supply_fail_n(second_supply_fail_n),
   .third_supply_fail_oe_n(third_supply_fail_oe_n),
   .watchdog_timeout_oe_n(watchdog_timeout_oe_n));

// ==== sim/testbench.sv ====
/* Self-checking bench of the supervisor with a host model on the bus.
   Assumes the design counts are shortened through its parameters. */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RLIM[4] = '{20, 30, 40, 50};
   localparam int WLIM[3] = '{60, 20000000, 140000000};
   logic clk_sys = 1'b0, nrst = 1'b0, main = 1'b1, s2 = 1'b1, s3 = 1'b1, mr_n = 1'b1;
   logic kick = 1'b0, wp = 1'b0, sw = 1'b0, scl, sda;
   logic [1:0] swd = 2'h0, srs = 2'h0, wd_sel, rst_sel;
   logic sys_rst, early_n, f2_n, f3o, f3oe_n, watchdog_timeout_n, wdoe_n;
   int fail_count = 0, n_tests = 0;
   host_bus_model host_u (.clk_sys(clk_sys), .kick(kick), .scl(scl), .sda(sda));
   // Only the shortest watchdog period is cut down; the two long ones keep their values.
   triple_supply_reset_supervisor #(.RST_CYC_0(28'h14), .RST_CYC_1(28'h1e),
      .RST_CYC_2(28'h28), .RST_CYC_3(28'h32), .WD_CYC_0(28'h3c))
      dut_u (.clk_sys(clk_sys), .nrst(nrst), .main_above_trip(main),
      .second_supply_sense(s2), .third_supply_sense(s3), .manual_reset_n(mr_n),
      .scl_in(scl), .sda_in(sda), .write_protect(wp), .set_write(sw), .set_wd_sel(swd),
      .set_rst_sel(srs), .wd_sel(wd_sel), .rst_sel(rst_sel), .system_reset(sys_rst),
      .early_low_supply_n(early_n), .second_supply_fail_n(f2_n),
      .third_supply_fail_out(f3o), .third_supply_fail_oe_n(f3oe_n),
      .watchdog_timeout_out(watchdog_timeout_n), .watchdog_timeout_oe_n(wdoe_n));
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wait_low(ref logic sig, output int n);
      n = 0;
      while (sig !== 1'b0 && n < 400) begin
         tick(1);
         n++;
      end
   endtask
   task automatic setsel(input logic p, input logic [1:0] w, input logic [1:0] r);
      @(posedge clk_sys);
      wp <= p;
      sw <= 1'b1;
      swd <= w;
      srs <= r;
      @(posedge clk_sys);
      sw <= 1'b0;
      tick(1);
   endtask
   task automatic kick_host();
      @(posedge clk_sys);
      kick <= 1'b1;
      @(posedge clk_sys);
      kick <= 1'b0;
      tick(8);
   endtask
   task automatic t_supply();
      @(posedge clk_sys);
      s2 <= 1'b0;
      s3 <= 1'b0;
      main <= 1'b0;
      tick(2);
      check({early_n, f2_n, f3oe_n, sys_rst}, 4'h1);
      @(posedge clk_sys);
      s2 <= 1'b1;
      s3 <= 1'b1;
      tick(2);
      check({early_n, f2_n, f3oe_n, sys_rst}, 4'h7);
      check({2'h0, f3o, watchdog_timeout_n}, 4'h0);
      $display("supply test done");
   endtask
   task automatic t_recover();
      int n;
      for (int s = 0; s < 4; s++) begin
         setsel(1'b0, 2'h3, s[1:0]);
         @(posedge clk_sys);
         main <= 1'b0;
         tick(3);
         @(posedge clk_sys);
         main <= 1'b1;
         wait_low(sys_rst, n);
         check(4'(n >= RLIM[s] && n <= RLIM[s] + 4), 4'h1);
      end
      $display("recover test done");
   endtask
   task automatic t_manual();
      int n;
      @(posedge clk_sys);
      mr_n <= 1'b0;
      tick(30);
      check(4'(sys_rst), 4'h1);
      @(posedge clk_sys);
      mr_n <= 1'b1;
      wait_low(sys_rst, n);
      check(4'(n >= RLIM[3] + 16 && n <= RLIM[3] + 22), 4'h1);
      $display("manual test done");
   endtask
   task automatic t_wp();
      setsel(1'b1, 2'h1, 2'h2);
      check({wd_sel, rst_sel}, 4'hf);
      setsel(1'b0, 2'h1, 2'h2);
      check({wd_sel, rst_sel}, 4'h6);
      $display("protect test done");
   endtask
   task automatic t_watchdog();
      int n;
      for (int s = 0; s < 3; s++) begin
         setsel(1'b0, s[1:0], 2'h0);
         repeat (4) kick_host();
         check(4'(wdoe_n), 4'h1);
         wait_low(wdoe_n, n);
         // A long period cannot run out in the wait, so it must outlast the whole wait.
         check(4'(WLIM[s] > 400 ? n == 400 : (n >= WLIM[s] - 8 && n <= WLIM[s] + 6)),
            4'h1);
      end
      setsel(1'b0, 2'h3, 2'h0);
      kick_host();
      tick(150);
      check(4'(wdoe_n), 4'h1);
      $display("watchdog test done");
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      #50000;
      fail_count++;
      test_done();
   end
   initial begin
      int n;
      repeat (6) @(posedge clk_sys);
      nrst <= 1'b1;
      wait_low(sys_rst, n);
      check(4'(n >= RLIM[0] && n <= RLIM[0] + 4), 4'h1);
      t_supply();
      t_recover();
      t_manual();
      t_wp();
      t_watchdog();
      test_done();
   end
endmodule
